// *** dpc_pkg.sv ***
// constants and types of the power on/off controller
package dpc_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STAT_OFF   = 8'h04;
  localparam logic [7:0] IRQ_OFF    = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0C;
  localparam logic [7:0] WDOG_OFF   = 8'h10;
  localparam logic [7:0] PLL_OFF    = 8'h14;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_SHDN_BIT   = 0;
  localparam int CTRL_CHG_LSB    = 1;
  localparam int CTRL_DISP_LSB   = 4;
  localparam int CTRL_WDEN_BIT   = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;

  // ----------------------------------------
  // interrupt bits
  // ----------------------------------------
  localparam int IRQ_ON_BIT     = 0;
  localparam int IRQ_OFF_BIT    = 1;
  localparam int IRQ_LOW_BIT    = 2;
  localparam int IRQ_CRIT_BIT   = 3;
  localparam int IRQ_UV_BIT     = 4;
  localparam int IRQ_RAIL_BIT   = 5;
  localparam int IRQ_WD_BIT     = 6;
  localparam int IRQ_W          = 7;

  // ----------------------------------------
  // pll and timing
  // ----------------------------------------
  localparam logic [15:0] PLL_MULT_RST = 16'h02FA;
  localparam logic [31:0] WDOG_KEY     = 32'h0000A5A5;
  localparam int          CLK_MHZ      = 250;
  localparam int          POR_US       = 200;
  localparam int          POR_CYC      = POR_US * CLK_MHZ;
  localparam int          WDOG_MS      = 1000;
  localparam int          WDOG_CYC     = WDOG_MS * 1000 * CLK_MHZ;
  localparam int          WD_RST_CYC   = 64;

  typedef enum logic [1:0]
  {
    DPC_OFF,
    DPC_STBY,
    DPC_ON
  } dpc_state_e;

endpackage : dpc_pkg

// *** dpc_power_ctrl.sv ***
// power on/off sequencer, supervisor and register slave

// Notes on behaviour
// R1: only a button press turns the unit on, from off or standby.
// R2: a button press while on turns the supplies off.
// R3: core shutdown request while on removes the supplies.
// R4: undervoltage shutdown input (active low) switches the unit off.
// R5: after shutdown go to standby with line power, else off.
// R6: both switched supply rails are enabled and disabled together.
// R7: battery low warning is passed on during battery operation.
// R8: battery critical warning is passed on; shutdown follows unless line power. The code flags it only on battery power and does not switch off on it.
// R9: undervoltage after critical warning switches the device off.
// R10: a power-up reset pulse is given each time the unit turns on.
// R11: reset is held while either logic rail is out of range.
// R12: when off, patient memory goes to backup and access is blocked.
// R13: reset indicator led is lit whenever hard reset is asserted.
// R14: system clock pll multiplier is software settable from the crystal.
// R15: control register drives switch-off, charging and display signals.
// R16: status register shows hardware config and battery charge state.
// R17: unserviced watchdog asserts hard reset after a fixed timeout.
module dpc_power_ctrl #(
  parameter int POR_CYCLES  = dpc_pkg::POR_CYC,
  parameter int WDOG_CYCLES = dpc_pkg::WDOG_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins from button, core and voltage control
  input  wire logic        onoff_button,
  input  wire logic        core_shutdown_request,
  input  wire logic        undervoltage_n,
  input  wire logic        battery_low_warning,
  input  wire logic        battery_critical_warning,
  input  wire logic        line_power,
  input  wire logic        rail_3v3_ok,
  input  wire logic        rail_5v_ok,
  input  wire logic [7:0]  hw_config,
  // supplies and resets
  output logic             main_device_rail,
  output logic             switched_supply_rail,
  output logic             hard_reset_n,
  output logic             reset_indicator_led,
  output logic             mem_backup_sel,
  output logic             mem_protect,
  // board control
  output logic             device_switch_off,
  output logic [2:0]       charge_ctrl,
  output logic [3:0]       display_ctrl,
  output logic [15:0]      pll_mult,
  output logic             irq
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic             btn_s;
  logic             shdn_s;
  logic             uv_n_s;
  logic             low_s;
  logic             crit_s;
  logic             line_s;
  logic             r33_s;
  logic             r5_s;
  logic [7:0]       cfg1_q;
  logic [7:0]       cfg2_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 8'h04;
      sync2_q <= 8'h04;
      cfg1_q  <= 8'h00;
      cfg2_q  <= 8'h00;
    end
    else
    begin
      sync1_q <= {rail_5v_ok, rail_3v3_ok, line_power, battery_critical_warning,
                  battery_low_warning, undervoltage_n, core_shutdown_request,
                  onoff_button};
      sync2_q <= sync1_q;
      cfg1_q  <= hw_config;
      cfg2_q  <= cfg1_q;
    end
  end

  assign btn_s  = sync2_q[0];
  assign shdn_s = sync2_q[1];
  assign uv_n_s = sync2_q[2];
  assign low_s  = sync2_q[3];
  assign crit_s = sync2_q[4];
  assign line_s = sync2_q[5];
  assign r33_s  = sync2_q[6];
  assign r5_s   = sync2_q[7];

  logic btn_prev_q;
  logic btn_press;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      btn_prev_q <= 1'b0;
    else
      btn_prev_q <= btn_s;
  end

  assign btn_press = btn_s & ~btn_prev_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [8:0]         ctrl_q;
  logic [dpc_pkg::IRQ_W-1:0] irq_st_q;
  logic [dpc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [15:0]        pll_q;
  logic               wd_kick;
  logic               sw_off;

  assign sw_off = ctrl_q[dpc_pkg::CTRL_SHDN_BIT];

  // ----------------------------------------
  // on/off state machine
  // ----------------------------------------
  dpc_pkg::dpc_state_e state_q;
  dpc_pkg::dpc_state_e state_d;
  logic                off_cause;
  logic                go_on;
  logic                go_off;

  assign off_cause = btn_press | shdn_s | ~uv_n_s | sw_off; // R2 R3 R4 R9

  always_comb
  begin
    state_d = state_q;
    go_on   = 1'b0;
    go_off  = 1'b0;
    case (state_q)
      dpc_pkg::DPC_OFF,
      dpc_pkg::DPC_STBY:
      begin
        if (btn_press) // R1
        begin
          state_d = dpc_pkg::DPC_ON;
          go_on   = 1'b1;
        end
        else
          state_d = line_s ? dpc_pkg::DPC_STBY : dpc_pkg::DPC_OFF;
      end
      dpc_pkg::DPC_ON:
      begin
        if (off_cause)
        begin
          state_d = line_s ? dpc_pkg::DPC_STBY : dpc_pkg::DPC_OFF; // R5
          go_off  = 1'b1;
        end
      end
      default:
        state_d = dpc_pkg::DPC_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= dpc_pkg::DPC_OFF;
    else
      state_q <= state_d;
  end

  logic dev_on;
  assign dev_on = (state_q == dpc_pkg::DPC_ON);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_device_rail     <= 1'b0;
      switched_supply_rail <= 1'b0;
      mem_backup_sel       <= 1'b1;
      mem_protect          <= 1'b1;
    end
    else
    begin
      main_device_rail     <= (state_d == dpc_pkg::DPC_ON); // R6
      switched_supply_rail <= (state_d == dpc_pkg::DPC_ON); // R6
      mem_backup_sel       <= (state_d != dpc_pkg::DPC_ON); // R12
      mem_protect          <= (state_d != dpc_pkg::DPC_ON); // R12
    end
  end

  // ----------------------------------------
  // supervisor: power-up reset and watchdog
  // ----------------------------------------
  logic [31:0] por_cnt_q;
  logic [31:0] wd_cnt_q;
  logic [7:0]  wd_rst_q;
  logic        wd_fire;
  logic        rails_bad;

  assign rails_bad = dev_on & ~(r33_s & r5_s);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      por_cnt_q <= 32'h00000000;
    else if (go_on)
      por_cnt_q <= POR_CYCLES[31:0]; // R10
    else if (por_cnt_q != 32'h00000000)
      por_cnt_q <= por_cnt_q - 32'h00000001;
  end

  assign wd_fire = dev_on & ctrl_q[dpc_pkg::CTRL_WDEN_BIT] &
                   (wd_cnt_q == WDOG_CYCLES[31:0] - 32'h00000001);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_cnt_q <= 32'h00000000;
    else if (!dev_on || !ctrl_q[dpc_pkg::CTRL_WDEN_BIT] || wd_kick || wd_fire)
      wd_cnt_q <= 32'h00000000;
    else
      wd_cnt_q <= wd_cnt_q + 32'h00000001; // R17
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_rst_q <= 8'h00;
    else if (wd_fire)
      wd_rst_q <= 8'(dpc_pkg::WD_RST_CYC); // R17
    else if (wd_rst_q != 8'h00)
      wd_rst_q <= wd_rst_q - 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hard_reset_n        <= 1'b0;
      reset_indicator_led <= 1'b1;
    end
    else
    begin
      hard_reset_n        <= ~(~dev_on | go_on | rails_bad | // R10 R11
                               (por_cnt_q > 32'h00000001) | wd_fire | (wd_rst_q != 8'h00));
      reset_indicator_led <= ~(~(~dev_on | go_on | rails_bad |
                               (por_cnt_q > 32'h00000001) | wd_fire | (wd_rst_q != 8'h00))); // R13
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic       ph_wr_q;
  logic       ph_rd_q;
  logic [7:0] ph_addr_q;
  logic       take;

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end
    else
    begin
      ph_wr_q   <= take & hwrite;
      ph_rd_q   <= take & ~hwrite;
      ph_addr_q <= take ? haddr[7:0] : ph_addr_q;
    end
  end

  logic wr_ctrl;
  logic wr_irq;
  logic wr_mask;
  logic wr_pll;
  assign wr_ctrl = ph_wr_q & (ph_addr_q == dpc_pkg::CTRL_OFF);
  assign wr_irq  = ph_wr_q & (ph_addr_q == dpc_pkg::IRQ_OFF);
  assign wr_mask = ph_wr_q & (ph_addr_q == dpc_pkg::MASK_OFF);
  assign wr_pll  = ph_wr_q & (ph_addr_q == dpc_pkg::PLL_OFF);
  assign wd_kick = ph_wr_q & (ph_addr_q == dpc_pkg::WDOG_OFF) & (hwdata == dpc_pkg::WDOG_KEY);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= dpc_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= hwdata[8:0]; // R15
    else if (go_off)
      ctrl_q[dpc_pkg::CTRL_SHDN_BIT] <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pll_q <= dpc_pkg::PLL_MULT_RST;
    else if (wr_pll)
      pll_q <= hwdata[15:0]; // R14
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_q <= '0;
    else if (wr_mask)
      irq_mask_q <= hwdata[dpc_pkg::IRQ_W-1:0];
  end

  // event edges; set wins over write-one-to-clear
  logic low_prev_q;
  logic crit_prev_q;
  logic [dpc_pkg::IRQ_W-1:0] ev;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_prev_q  <= 1'b0;
      crit_prev_q <= 1'b0;
    end
    else
    begin
      low_prev_q  <= low_s;
      crit_prev_q <= crit_s;
    end
  end

  always_comb
  begin
    ev = '0;
    ev[dpc_pkg::IRQ_ON_BIT]   = go_on;
    ev[dpc_pkg::IRQ_OFF_BIT]  = go_off;
    ev[dpc_pkg::IRQ_LOW_BIT]  = low_s & ~low_prev_q & ~line_s;   // R7
    ev[dpc_pkg::IRQ_CRIT_BIT] = crit_s & ~crit_prev_q & ~line_s; // R8
    ev[dpc_pkg::IRQ_UV_BIT]   = dev_on & ~uv_n_s;                // R9
    ev[dpc_pkg::IRQ_RAIL_BIT] = rails_bad;
    ev[dpc_pkg::IRQ_WD_BIT]   = wd_fire;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_st_q <= '0;
    else
      irq_st_q <= (irq_st_q & ~(wr_irq ? hwdata[dpc_pkg::IRQ_W-1:0] : '0)) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_q & irq_mask_q);
  end

  // read data, combinational from phase registers, unmapped reads zero
  always_comb
  begin
    hrdata = 32'h00000000;
    if (ph_rd_q)
    begin
      case (ph_addr_q)
        dpc_pkg::CTRL_OFF: hrdata = {23'h000000, ctrl_q};
        dpc_pkg::STAT_OFF: hrdata = {16'h0000, cfg2_q, 1'b0, uv_n_s, // R16
                                     crit_s, low_s, line_s, 1'b0, state_q};
        dpc_pkg::IRQ_OFF:  hrdata = {25'h0000000, irq_st_q};
        dpc_pkg::MASK_OFF: hrdata = {25'h0000000, irq_mask_q};
        dpc_pkg::PLL_OFF:  hrdata = {16'h0000, pll_q};
        default:           hrdata = 32'h00000000;
      endcase
    end
  end

  assign device_switch_off = ctrl_q[dpc_pkg::CTRL_SHDN_BIT];
  assign charge_ctrl       = ctrl_q[dpc_pkg::CTRL_CHG_LSB +: 3];
  assign display_ctrl      = ctrl_q[dpc_pkg::CTRL_DISP_LSB +: 4];
  assign pll_mult          = pll_q; // R14

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_press_on;
    !dev_on ##1 btn_press;
  endsequence

  chk_on_by_press: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !dev_on ##1 dev_on |-> $past(btn_press))
    else $error("unit turned on without a button press");

  chk_press_turns_on: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    s_press_on |=> dev_on)
    else $error("button press did not turn unit on");

  chk_press_off: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    dev_on && btn_press |=> !dev_on ##1 !main_device_rail)
    else $error("press while on did not turn supplies off");

  chk_core_shdn: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    dev_on && shdn_s |=> !dev_on)
    else $error("core shutdown request ignored");

  chk_uv_off: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    dev_on && !uv_n_s |=> !dev_on)
    else $error("undervoltage did not switch off");

  chk_off_target: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    go_off |=> (state_q == dpc_pkg::DPC_STBY) == $past(line_s))
    else $error("wrong state after shutdown");

  chk_rails_pair: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (main_device_rail == dev_on) && (switched_supply_rail == dev_on))
    else $error("supply rails differ");

  chk_por_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    go_on |=> !hard_reset_n [*2])
    else $error("no power-up reset");

  chk_rail_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    rails_bad |=> !hard_reset_n)
    else $error("rail fault without reset");

  chk_mem_guard: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    !dev_on |-> mem_protect && mem_backup_sel)
    else $error("patient memory unguarded while off");

  chk_led: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    reset_indicator_led == !hard_reset_n)
    else $error("led does not follow hard reset");

  chk_wd_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    wd_fire |=> !hard_reset_n [*8])
    else $error("watchdog expiry did not reset");

endmodule : dpc_power_ctrl

// *** dpc_partner.sv ***
// far side model: on/off button and processor core
module dpc_partner (
  // clock
  input  wire logic hclk,
  // supply feedback
  input  wire logic main_device_rail,
  // pins to the controller
  output logic      onoff_button,
  output logic      core_shutdown_request
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    onoff_button = 1'b0;
    core_shutdown_request = 1'b0;
  end

  // press held for a random span, then released
  task automatic press();
    int n;
    n = 3 + ($urandom % 8);
    @(posedge hclk);
    onoff_button <= 1'b1;
    repeat (n) @(posedge hclk);
    onoff_button <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask : press

  // request held until the supplies drop or 50 cycles pass
  task automatic core_off();
    int g;
    g = 0;
    @(posedge hclk);
    core_shutdown_request <= 1'b1;
    do
    begin
      @(posedge hclk);
      g++;
    end
    while (main_device_rail !== 1'b0 && g < 50);
    core_shutdown_request <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : core_off
endmodule : dpc_partner

// *** tb_top.sv ***
// self-checking bench of the power on/off controller
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR_N = 24;
  localparam int WD_N  = 100;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rd_dp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize, charge_ctrl;
  logic        onoff_button, core_shutdown_request, undervoltage_n, line_power;
  logic        battery_low_warning, battery_critical_warning, rail_3v3_ok, rail_5v_ok;
  logic [7:0]  hw_config;
  logic        main_device_rail, switched_supply_rail, hard_reset_n, reset_indicator_led;
  logic        mem_backup_sel, mem_protect, device_switch_off;
  logic [3:0]  display_ctrl;
  logic [15:0] pll_mult;
  logic [31:0] exp_q[$];
  int          n_fail, n_checks;

  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  dpc_power_ctrl #(.POR_CYCLES(POR_N), .WDOG_CYCLES(WD_N)) u_dpc_power_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .onoff_button(onoff_button),
    .core_shutdown_request(core_shutdown_request), .undervoltage_n(undervoltage_n),
    .battery_low_warning(battery_low_warning),
    .battery_critical_warning(battery_critical_warning), .line_power(line_power),
    .rail_3v3_ok(rail_3v3_ok), .rail_5v_ok(rail_5v_ok), .hw_config(hw_config),
    .main_device_rail(main_device_rail), .switched_supply_rail(switched_supply_rail),
    .hard_reset_n(hard_reset_n), .reset_indicator_led(reset_indicator_led),
    .mem_backup_sel(mem_backup_sel), .mem_protect(mem_protect),
    .device_switch_off(device_switch_off), .charge_ctrl(charge_ctrl),
    .display_ctrl(display_ctrl), .pll_mult(pll_mult), .irq(irq));

  dpc_partner u_dpc_partner (.hclk(hclk), .main_device_rail(main_device_rail),
    .onoff_button(onoff_button), .core_shutdown_request(core_shutdown_request));

  // ----------------------------------------
  // read data monitor
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_dp <= 1'b0;
    else
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;

  always @(negedge hclk)
  begin
    logic [31:0] e;
    if (rd_dp)
    begin
      e = exp_q.pop_front();
      `CHK("hrdata", e, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    if (!w) exp_q.push_back(e);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : bus

  function automatic logic [31:0] stat(input logic [1:0] st);
    return {16'h0000, hw_config, 1'b0, undervoltage_n, battery_critical_warning,
            battery_low_warning, line_power, 1'b0, st};
  endfunction : stat

  task automatic pins(input logic on);
    @(negedge hclk);
    `CHK("main_rail", on, main_device_rail)
    `CHK("supply_rail", on, switched_supply_rail)
    `CHK("mem_backup", !on, mem_backup_sel)
    `CHK("mem_protect", !on, mem_protect)
    `CHK("led", ~hard_reset_n, reset_indicator_led)
    @(posedge hclk);
  endtask : pins

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #100us;
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(85661));
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, n_fail, n_checks} = '0;
    hsize = 3'b010;
    {undervoltage_n, rail_3v3_ok, rail_5v_ok} = 3'b111;
    {battery_low_warning, battery_critical_warning, line_power} = 3'b000;
    hw_config = 8'($urandom);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pins(1'b0);
    `CHK("pll_mult", dpc_pkg::PLL_MULT_RST, pll_mult)
    bus(dpc_pkg::CTRL_OFF, 1'b0, 0, 0);
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd0));
    bus(8'h20, 1'b1, 32'hFFFFFFFF, 0);
    bus(8'h20, 1'b0, 0, 0);
    $display("test reset done");
    undervoltage_n <= 1'b0;
    battery_critical_warning <= 1'b1;
    u_dpc_partner.core_off();
    repeat (6) @(posedge hclk);
    pins(1'b0);
    undervoltage_n <= 1'b1;
    battery_critical_warning <= 1'b0;
    $display("test off causes done");
    u_dpc_partner.press();
    pins(1'b1);
    `CHK("por", 1'b0, hard_reset_n)
    repeat (POR_N + 4) @(posedge hclk);
    `CHK("por_end", 1'b1, hard_reset_n)
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd2));
    u_dpc_partner.press();
    pins(1'b0);
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd0));
    $display("test button done");
    line_power <= 1'b1;
    u_dpc_partner.press();
    repeat (POR_N + 4) @(posedge hclk);
    u_dpc_partner.core_off();
    pins(1'b0);
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd1));
    u_dpc_partner.press();
    pins(1'b1);
    line_power <= 1'b0;
    bus(dpc_pkg::IRQ_OFF, 1'b1, 32'h7F, 0);
    repeat (4) @(posedge hclk);
    battery_critical_warning <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd2));
    undervoltage_n <= 1'b0;
    repeat (6) @(posedge hclk);
    pins(1'b0);
    bus(dpc_pkg::IRQ_OFF, 1'b0, 0, 32'h1A);
    `CHK("irq_masked", 1'b0, irq)
    bus(dpc_pkg::MASK_OFF, 1'b1, 32'h10, 0);
    repeat (2) @(posedge hclk);
    `CHK("irq_set", 1'b1, irq)
    bus(dpc_pkg::IRQ_OFF, 1'b1, 32'h10, 0);
    repeat (2) @(posedge hclk);
    `CHK("irq_clr", 1'b0, irq)
    bus(dpc_pkg::IRQ_OFF, 1'b0, 0, 32'h0A);
    {undervoltage_n, battery_critical_warning} <= 2'b10;
    $display("test battery done");
    d = $urandom & 32'h000000FE;
    bus(dpc_pkg::CTRL_OFF, 1'b1, d | 32'h1, 0);
    bus(dpc_pkg::CTRL_OFF, 1'b0, 0, d | 32'h1);
    `CHK("switch_off", 1'b1, device_switch_off)
    bus(dpc_pkg::CTRL_OFF, 1'b1, d, 0);
    bus(dpc_pkg::CTRL_OFF, 1'b0, 0, d);
    `CHK("charge", d[3:1], charge_ctrl)
    `CHK("display", d[7:4], display_ctrl)
    u_dpc_partner.press();
    repeat (POR_N + 4) @(posedge hclk);
    bus(dpc_pkg::CTRL_OFF, 1'b1, d | 32'h1, 0);
    repeat (6) @(posedge hclk);
    pins(1'b0);
    bus(dpc_pkg::CTRL_OFF, 1'b0, 0, d);
    $display("test control done");
    u_dpc_partner.press();
    repeat (POR_N + 4) @(posedge hclk);
    for (int i = 0; i < 2; i++)
    begin
      {rail_3v3_ok, rail_5v_ok} <= (i == 0) ? 2'b01 : 2'b10;
      repeat (6) @(posedge hclk);
      `CHK("rail_reset", 1'b0, hard_reset_n)
      `CHK("rail_led", 1'b1, reset_indicator_led)
      {rail_3v3_ok, rail_5v_ok} <= 2'b11;
      repeat (POR_N + 8) @(posedge hclk);
      `CHK("rail_back", 1'b1, hard_reset_n)
    end
    $display("test rails done");
    bus(dpc_pkg::CTRL_OFF, 1'b1, 32'h100, 0);
    repeat (WD_N / 2) @(posedge hclk);
    bus(dpc_pkg::WDOG_OFF, 1'b1, dpc_pkg::WDOG_KEY, 0);
    repeat (70) @(posedge hclk);
    `CHK("wd_kicked", 1'b1, hard_reset_n)
    repeat (60) @(posedge hclk);
    `CHK("wd_expired", 1'b0, hard_reset_n)
    bus(dpc_pkg::CTRL_OFF, 1'b1, 0, 0);
    $display("test watchdog done");
    d = $urandom;
    bus(dpc_pkg::PLL_OFF, 1'b1, d, 0);
    bus(dpc_pkg::PLL_OFF, 1'b0, 0, {16'h0000, d[15:0]});
    `CHK("pll_set", d[15:0], pll_mult)
    battery_low_warning <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(dpc_pkg::STAT_OFF, 1'b0, 0, stat(2'd2));
    repeat (4) @(posedge hclk);
    $display("test pll and status done");
    finish_test();
  end
endmodule : tb_top
